// File: src/pot_pkg.sv
// Shared constants for the wiper command target and its bus controller
// Contract
// - Decrement acts only on wiper addresses 0, 1
// - Accepted decrement lowers wiper by one step
// - Wiper at zero stays zero on decrement
// - Wiper changes right after command acknowledge
// - Reserved wiper values ignore decrement
// - Commands chain freely; controller ends with Stop
// - High-voltage input level sets high-voltage mode
// - Controller waits set-up after raising high voltage
// - Recovery: Start, nine ones, Start, Stop
// - Start resets receive state, wipers kept
// - Not-acknowledge on read releases bus, resets
// - Start before Stop cancels interrupted write
// - After Stop stay idle until Start
// - General call accepts increment, decrement, write
// - Invalid command: release SDA, wait for Start
package pot_pkg;
  localparam int          WIPER_W      = 10;
  localparam int          RES_BITS_DEF = 8;
  localparam int          SYS_MHZ      = 50;
  localparam int          SCL_QTR_NS   = 625;
  localparam int          SCL_QTR_CYC  = SCL_QTR_NS * SYS_MHZ / 1000;
  localparam int          HV_SETUP_NS  = 10000;
  localparam int          HV_SETUP_CYC = (HV_SETUP_NS * SYS_MHZ + 999) / 1000;
  localparam int          CNT_W        = 16;
  localparam logic [5:0]  ADDR_HI_DEF  = 6'h17;
  localparam logic [7:0]  GCALL_ADDR   = 8'h00;
  localparam logic [3:0]  WIPER0_ADDR  = 4'h0;
  localparam logic [3:0]  WIPER1_ADDR  = 4'h1;
  localparam logic [1:0]  OP_WRITE     = 2'h0;
  localparam logic [1:0]  OP_INC       = 2'h1;
  localparam logic [1:0]  OP_DEC       = 2'h2;
  localparam logic [1:0]  OP_READ      = 2'h3;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [4:0]  RECOVER_ONES = 5'h09;
  localparam logic [4:0]  CMD_BITS     = 5'h12;
  localparam logic [4:0]  WRITE_BITS   = 5'h1b;
endpackage

// File: src/pot_link_if.sv
// Two-wire link between the bus controller and the wiper target
`timescale 1ns/1ps
`default_nettype none
interface pot_link_if;
  logic scl;
  logic sda_ctl_o;
  logic sda_ctl_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;
  logic hv_level;
  logic addr0;
  // Open-drain wired AND with pull-up
  assign sda = !((sda_ctl_oe && !sda_ctl_o) || (sda_dev_oe && !sda_dev_o));
  modport controller (output scl, sda_ctl_o, sda_ctl_oe, hv_level, addr0,
                      input sda);
  modport target (input scl, sda, hv_level, addr0,
                  output sda_dev_o, sda_dev_oe);
endinterface
`default_nettype wire

// File: src/wiper_target.sv
// Target end: command decoder and two volatile wipers
`timescale 1ns/1ps
`default_nettype none
module wiper_target
  import pot_pkg::*;
#(
  parameter int         RES_BITS = RES_BITS_DEF,
  parameter logic [5:0] ADDR_HI  = ADDR_HI_DEF
) (
  input  wire logic          CLOCK,
  input  wire logic          RST,
  pot_link_if.target         LINK,
  output logic [WIPER_W-1:0] WIPER0,
  output logic [WIPER_W-1:0] WIPER1,
  output logic               HV_MODE
);
  typedef enum logic [2:0] {P_IDLE, P_ADDR, P_CMD, P_DATA, P_RD, P_IGN} phase_e;

  localparam logic [WIPER_W-1:0] FULL = WIPER_W'(1 << RES_BITS);
  localparam logic [WIPER_W-1:0] MID  = FULL >> 1;

  function automatic logic [WIPER_W-1:0] step_down(
    input logic [WIPER_W-1:0] w);
    // Zero and reserved values hold
    if (w == '0 || w > FULL)
      step_down = w;
    else
      step_down = w - WIPER_W'(1);
  endfunction

  function automatic logic [WIPER_W-1:0] step_up(
    input logic [WIPER_W-1:0] w);
    if (w >= FULL)
      step_up = w;
    else
      step_up = w + WIPER_W'(1);
  endfunction

  logic [1:0]         scl_m;
  logic [1:0]         sda_m;
  logic [1:0]         hv_m;
  logic [1:0]         a0_m;
  logic               scl_d;
  logic               sda_d;
  phase_e             phase_reg;
  logic [3:0]         cnt_reg;
  logic               ack_slot_reg;
  logic               oe_reg;
  logic [7:0]         sh_reg;
  logic               rw_reg;
  logic               gc_reg;
  logic               nack_reg;
  logic               ptr_reg;
  logic [1:0]         op_reg;
  logic [1:0]         d98_reg;
  logic [15:0]        tx_reg;
  logic               rd_hi_reg;
  logic [WIPER_W-1:0] wip [2];
  logic               scl_rise;
  logic               scl_fall;
  logic               start_c;
  logic               stop_c;
  logic               ack_end;
  logic               addr_hit;
  logic               gc_hit;
  logic               cmd_ok;
  logic [15:0]        rd_word;

  // Two-flop synchronisers; the second stage, plus a third delay flop on SCL and SDA, feeds logic
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      scl_m <= 2'h3;
      sda_m <= 2'h3;
      hv_m  <= 2'h0;
      a0_m  <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= {scl_m[0], LINK.scl};
      sda_m <= {sda_m[0], LINK.sda};
      hv_m  <= {hv_m[0], LINK.hv_level};
      a0_m  <= {a0_m[0], LINK.addr0};
      scl_d <= scl_m[1];
      sda_d <= sda_m[1];
    end
  end

  assign scl_rise = scl_m[1] && !scl_d;
  assign scl_fall = !scl_m[1] && scl_d;
  assign start_c  = scl_m[1] && scl_d && sda_d && !sda_m[1];
  assign stop_c   = scl_m[1] && scl_d && !sda_d && sda_m[1];
  assign addr_hit = sh_reg[7:1] == {ADDR_HI, a0_m[1]};
  assign gc_hit   = sh_reg == GCALL_ADDR;
  // Only the two volatile wipers take commands; no read via general call
  assign cmd_ok   = (sh_reg[7:4] == WIPER0_ADDR ||
                     sh_reg[7:4] == WIPER1_ADDR) &&
                    !(gc_reg && sh_reg[3:2] == OP_READ);
  assign rd_word  = {{(16 - WIPER_W){1'b0}}, wip[ptr_reg]};
  assign ack_end  = scl_fall && ack_slot_reg &&
                    (phase_reg == P_CMD || phase_reg == P_DATA);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      phase_reg    <= P_IDLE;
      cnt_reg      <= 4'h0;
      ack_slot_reg <= 1'b0;
      oe_reg       <= 1'b0;
      sh_reg       <= 8'h00;
      rw_reg       <= 1'b0;
      gc_reg       <= 1'b0;
      nack_reg     <= 1'b0;
      ptr_reg      <= 1'b0;
      op_reg       <= OP_READ;
      d98_reg      <= 2'h0;
      tx_reg       <= 16'h0000;
      rd_hi_reg    <= 1'b0;
      HV_MODE      <= 1'b0;
    end else if (start_c) begin
      // Start drops any half-received command; wipers untouched
      phase_reg    <= P_ADDR;
      cnt_reg      <= 4'h0;
      ack_slot_reg <= 1'b0;
      oe_reg       <= 1'b0;
      HV_MODE      <= hv_m[1];
    end else if (stop_c) begin
      phase_reg    <= P_IDLE;
      ack_slot_reg <= 1'b0;
      oe_reg       <= 1'b0;
    end else if (phase_reg == P_IDLE || phase_reg == P_IGN) begin
      oe_reg <= 1'b0;
    end else if (scl_rise) begin
      if (ack_slot_reg) begin
        nack_reg <= sda_m[1];
      end else if (cnt_reg < BYTE_BITS) begin
        sh_reg  <= {sh_reg[6:0], sda_m[1]};
        cnt_reg <= cnt_reg + 4'h1;
      end
    end else if (scl_fall) begin
      if (ack_slot_reg) begin
        ack_slot_reg <= 1'b0;
        cnt_reg      <= 4'h0;
        oe_reg       <= 1'b0;
        case (phase_reg)
          P_ADDR: begin
            if (rw_reg) begin
              phase_reg <= P_RD;
              tx_reg    <= rd_word << 1;
              oe_reg    <= !rd_word[15];
              rd_hi_reg <= 1'b1;
            end else begin
              phase_reg <= P_CMD;
            end
          end
          P_CMD: begin
            // Chained commands need no new Start
            if (op_reg == OP_WRITE)
              phase_reg <= P_DATA;
          end
          P_DATA: phase_reg <= P_CMD;
          P_RD: begin
            if (nack_reg) begin
              phase_reg <= P_IGN;
            end else if (rd_hi_reg) begin
              oe_reg    <= !tx_reg[15];
              tx_reg    <= tx_reg << 1;
              rd_hi_reg <= 1'b0;
            end else begin
              tx_reg    <= rd_word << 1;
              oe_reg    <= !rd_word[15];
              rd_hi_reg <= 1'b1;
            end
          end
          default: phase_reg <= P_IGN;
        endcase
      end else if (cnt_reg == BYTE_BITS) begin
        ack_slot_reg <= 1'b1;
        case (phase_reg)
          P_ADDR: begin
            if (addr_hit || gc_hit) begin
              oe_reg <= 1'b1;
              rw_reg <= addr_hit && sh_reg[0];
              gc_reg <= gc_hit;
            end else begin
              phase_reg <= P_IGN;
            end
          end
          P_CMD: begin
            if (cmd_ok) begin
              oe_reg  <= 1'b1;
              ptr_reg <= sh_reg[4];
              op_reg  <= sh_reg[3:2];
              d98_reg <= sh_reg[1:0];
            end else begin
              phase_reg <= P_IGN;
            end
          end
          P_DATA: oe_reg <= 1'b1;
          default: oe_reg <= 1'b0;
        endcase
      end else if (phase_reg == P_RD) begin
        oe_reg <= !tx_reg[15];
        tx_reg <= tx_reg << 1;
      end
    end
  end

  // Wipers move on the falling edge that closes the acknowledge
  for (genvar i = 0; i < 2; i++) begin : g_wiper
    always_ff @(posedge CLOCK) begin
      if (RST) begin
        wip[i] <= MID;
      end else if (ack_end && ptr_reg == 1'(i)) begin
        if (phase_reg == P_DATA)
          wip[i] <= {d98_reg, sh_reg};
        else if (op_reg == OP_INC)
          wip[i] <= step_up(wip[i]);
        else if (op_reg == OP_DEC)
          wip[i] <= step_down(wip[i]);
      end
    end
  end

  assign WIPER0          = wip[0];
  assign WIPER1          = wip[1];
  assign LINK.sda_dev_oe = oe_reg;
  assign LINK.sda_dev_o  = 1'b0;
endmodule
`default_nettype wire

// File: src/pot_bus_ctl.sv
// Controller end: issues wiper commands and the bus recovery sequence
`timescale 1ns/1ps
`default_nettype none
module pot_bus_ctl
  import pot_pkg::*;
#(
  parameter int QTR_CYC = SCL_QTR_CYC,
  parameter int HV_CYC  = HV_SETUP_CYC
) (
  input  wire logic         CLOCK,
  input  wire logic         RST,
  pot_link_if.controller    LINK,
  input  wire logic         REQ,
  input  wire logic         RECOVER,
  input  wire logic         GCALL,
  input  wire logic         HV,
  input  wire logic         A0,
  input  wire logic [1:0]   OP,
  input  wire logic [3:0]   ADDR,
  input  wire logic [9:0]   DATA,
  output logic              BUSY,
  output logic              DONE,
  output logic              ACK_OK
);
  typedef enum logic [2:0] {C_IDLE, C_HVW, C_STA, C_BIT, C_RSTA, C_STO,
                            C_FIN} ctl_state_e;

  ctl_state_e       st_reg;
  logic [CNT_W-1:0] tmr_reg;
  logic [1:0]       q_reg;
  logic [26:0]      frame_reg;
  logic [4:0]       nbits_reg;
  logic [4:0]       bidx_reg;
  logic             rec_reg;
  logic             nack_reg;
  logic [1:0]       sda_m;
  logic             tick;
  logic             ack_slot;
  logic [7:0]       ctrl_byte;

  // SDA from the target is a pin: two flops before use
  always_ff @(posedge CLOCK) begin
    if (RST)
      sda_m <= 2'h3;
    else
      sda_m <= {sda_m[0], LINK.sda};
  end

  assign tick      = tmr_reg == CNT_W'(QTR_CYC - 1);
  assign ack_slot  = !rec_reg && (bidx_reg == 5'd8 || bidx_reg == 5'd17 ||
                                  bidx_reg == 5'd26);
  assign ctrl_byte = GCALL ? GCALL_ADDR : {ADDR_HI_DEF, A0, 1'b0};

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_reg          <= C_IDLE;
      tmr_reg         <= '0;
      q_reg           <= 2'h0;
      frame_reg       <= '0;
      nbits_reg       <= 5'h0;
      bidx_reg        <= 5'h0;
      rec_reg         <= 1'b0;
      nack_reg        <= 1'b0;
      BUSY            <= 1'b0;
      DONE            <= 1'b0;
      ACK_OK          <= 1'b0;
      LINK.scl        <= 1'b1;
      LINK.sda_ctl_oe <= 1'b0;
      LINK.sda_ctl_o  <= 1'b0;
      LINK.hv_level   <= 1'b0;
      LINK.addr0      <= 1'b0;
    end else begin
      DONE <= 1'b0;
      if (st_reg != C_IDLE)
        tmr_reg <= tick ? '0 : tmr_reg + CNT_W'(1);
      if (tick && st_reg != C_HVW)
        q_reg <= q_reg + 2'h1;
      case (st_reg)
        C_IDLE: begin
          if (REQ || RECOVER) begin
            BUSY          <= 1'b1;
            tmr_reg       <= '0;
            q_reg         <= 2'h0;
            bidx_reg      <= 5'h0;
            nack_reg      <= 1'b0;
            rec_reg       <= RECOVER;
            LINK.addr0    <= A0;
            LINK.hv_level <= HV && !RECOVER;
            if (RECOVER) begin
              frame_reg <= {9'h1ff, 18'h3ffff};
              nbits_reg <= RECOVER_ONES;
            end else begin
              frame_reg <= {ctrl_byte, 1'b1, ADDR, OP, DATA[9:8], 1'b1,
                            DATA[7:0], 1'b1};
              nbits_reg <= (OP == OP_WRITE) ? WRITE_BITS : CMD_BITS;
            end
            st_reg <= (HV && !RECOVER) ? C_HVW : C_STA;
          end
        end
        C_HVW: begin
          // No SCL edge until the high-voltage set-up time has passed
          tmr_reg <= tmr_reg + CNT_W'(1);
          if (tmr_reg == CNT_W'(HV_CYC - 1)) begin
            tmr_reg <= '0;
            st_reg  <= C_STA;
          end
        end
        C_STA: if (tick) begin
          case (q_reg)
            2'h0: LINK.sda_ctl_oe <= 1'b0;
            2'h1: LINK.sda_ctl_oe <= 1'b1;
            2'h2: LINK.scl <= 1'b0;
            default: st_reg <= C_BIT;
          endcase
        end
        C_BIT: if (tick) begin
          case (q_reg)
            2'h0: LINK.sda_ctl_oe <= !frame_reg[26];
            2'h1: LINK.scl <= 1'b1;
            2'h2: if (ack_slot && sda_m[1]) nack_reg <= 1'b1;
            default: begin
              LINK.scl  <= 1'b0;
              // Let go of SDA as SCL falls into an ack slot, so the
              // target's acknowledge never overlaps our last data bit
              if (!rec_reg && (bidx_reg == 5'd7 || bidx_reg == 5'd16 ||
                               bidx_reg == 5'd25))
                LINK.sda_ctl_oe <= 1'b0;
              frame_reg <= frame_reg << 1;
              bidx_reg  <= bidx_reg + 5'h1;
              if (bidx_reg == nbits_reg - 5'h1)
                st_reg <= rec_reg ? C_RSTA : C_STO;
            end
          endcase
        end
        C_RSTA: if (tick) begin
          // Second Start voids any write left half done
          case (q_reg)
            2'h0: LINK.sda_ctl_oe <= 1'b0;
            2'h1: LINK.scl <= 1'b1;
            2'h2: LINK.sda_ctl_oe <= 1'b1;
            default: begin
              LINK.scl <= 1'b0;
              st_reg   <= C_STO;
            end
          endcase
        end
        C_STO: if (tick) begin
          case (q_reg)
            2'h0: LINK.sda_ctl_oe <= 1'b1;
            2'h1: LINK.scl <= 1'b1;
            2'h2: LINK.sda_ctl_oe <= 1'b0;
            default: st_reg <= C_FIN;
          endcase
        end
        C_FIN: begin
          BUSY          <= 1'b0;
          DONE          <= 1'b1;
          ACK_OK        <= !nack_reg;
          LINK.hv_level <= 1'b0;
          st_reg        <= C_IDLE;
        end
        default: st_reg <= C_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: sim/pot_link_monitor.sv
// Concurrent checks on the shared wires between controller and target
`timescale 1ns/1ps
`default_nettype none
module pot_link_monitor #(
  parameter int QTR_CYC = 31,
  parameter int HV_CYC  = 500
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic scl,
  input wire logic sda_ctl_o,
  input wire logic sda_ctl_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda,
  input wire logic hv_level,
  input wire logic addr0
);
  logic        scl_q;
  logic        sda_q;
  logic        in_frame_reg;
  logic [15:0] oe_len_reg;
  logic [15:0] hv_age_reg;
  wire         start_seen = scl && scl_q && sda_q && !sda;
  wire         stop_seen  = scl && scl_q && !sda_q && sda;
  always_ff @(posedge CLOCK) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  always_ff @(posedge CLOCK) begin
    if (RST || stop_seen) in_frame_reg <= 1'h0;
    else if (start_seen) in_frame_reg <= 1'h1;
  end
  // Bounds how long the target may hold the line low
  always_ff @(posedge CLOCK) begin
    if (RST || !sda_dev_oe) oe_len_reg <= 16'h0;
    else oe_len_reg <= oe_len_reg + 16'h1;
  end
  // Saturates so a long high-voltage session cannot wrap
  always_ff @(posedge CLOCK) begin
    if (RST || !hv_level) hv_age_reg <= 16'h0;
    else if (hv_age_reg != 16'hffff) hv_age_reg <= hv_age_reg + 16'h1;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  chk_hv_setup_wait: assert property (
    hv_level && (scl != scl_q) |-> hv_age_reg >= HV_CYC + 2 * QTR_CYC)
    else $error("clock moved before high-voltage set-up ended");
  chk_oe_scl_low: assert property (
    $changed(sda_dev_oe) |-> !scl)
    else $error("target changed data line while clock high");
  chk_ack_released: assert property (
    sda_dev_oe |-> oe_len_reg < 4 * QTR_CYC + 6)
    else $error("target held data line too long");
  chk_start_resets: assert property (
    start_seen |=> !sda_dev_oe [*8])
    else $error("target drove line right after start");
  chk_stop_idle: assert property (
    $rose(sda_dev_oe) |-> in_frame_reg)
    else $error("target drove line outside a frame");
  chk_ack_timing: assert property (
    $rose(sda_dev_oe) |-> !scl && !$past(scl, 2) && $past(scl, 6))
    else $error("acknowledge not placed after clock fall");
  chk_ctl_yields: assert property (
    sda_dev_oe |-> !sda_ctl_oe)
    else $error("both ends drive the data line");
  chk_idle_clock: assert property (
    !in_frame_reg && !start_seen |-> scl)
    else $error("clock low outside a frame");
  chk_addr_steady: assert property (
    in_frame_reg |-> $stable(addr0))
    else $error("address pin moved inside a frame");
endmodule
`default_nettype wire

// File: sim/test_wiper_decrement_i2c_recovery.sv
// Bench joining controller and target, checking wipers and wire traffic
`timescale 1ns/1ps
`default_nettype none
module test_wiper_decrement_i2c_recovery
  import pot_pkg::*;
;
  localparam int QTR = 6;
  localparam int HIGH_VOLTAGE_COMMAND_INPUT = 10;
  logic       CLOCK = 1'h0;
  logic       RST = 1'h1;
  logic       REQ = 1'h0;
  logic       RECOVER = 1'h0;
  logic       GCALL = 1'h0;
  logic       HV = 1'h0;
  logic       A0 = 1'h0;
  logic [1:0] OP = 2'h0;
  logic [3:0] ADDR = 4'h0;
  logic [9:0] DATA = 10'h0;
  logic [9:0] WIPER0, WIPER1, e0, e1;
  logic [9:0] snap0 = 10'h080;
  logic [9:0] snap1 = 10'h080;
  logic       HV_MODE, BUSY, DONE, ACK_OK, scl_p, sda_p, oe_p;
  int         fail_count = 0;
  int         n_compared = 0;
  int         rises = 0;
  int         acks = 0;
  logic [9:0] vals [4] = '{10'h3ff, 10'h101, 10'h100, 10'h001};
  logic [9:0] outs [4] = '{10'h3ff, 10'h101, 10'h0ff, 10'h000};
  pot_link_if u_pot_link_if ();
  wire scl = u_pot_link_if.scl;
  wire sda = u_pot_link_if.sda;
  wire doe = u_pot_link_if.sda_dev_oe;
  always #10 CLOCK = ~CLOCK;
  wiper_target u_wiper_target (.CLOCK(CLOCK), .RST(RST),
    .LINK(u_pot_link_if), .WIPER0(WIPER0), .WIPER1(WIPER1),
    .HV_MODE(HV_MODE));
  pot_bus_ctl #(.QTR_CYC(QTR), .HV_CYC(HIGH_VOLTAGE_COMMAND_INPUT)) u_pot_bus_ctl (
    .CLOCK(CLOCK), .RST(RST), .LINK(u_pot_link_if), .REQ(REQ),
    .RECOVER(RECOVER), .GCALL(GCALL), .HV(HV), .A0(A0), .OP(OP),
    .ADDR(ADDR), .DATA(DATA), .BUSY(BUSY), .DONE(DONE), .ACK_OK(ACK_OK));
  pot_link_monitor #(.QTR_CYC(QTR), .HV_CYC(HIGH_VOLTAGE_COMMAND_INPUT)) u_pot_link_monitor (
    .CLOCK(CLOCK), .RST(RST), .scl(scl),
    .sda_ctl_o(u_pot_link_if.sda_ctl_o),
    .sda_ctl_oe(u_pot_link_if.sda_ctl_oe),
    .sda_dev_o(u_pot_link_if.sda_dev_o), .sda_dev_oe(doe), .sda(sda),
    .hv_level(u_pot_link_if.hv_level), .addr0(u_pot_link_if.addr0));
  // Wiper snapshot at Stop shows the update came before the frame closed
  always @(posedge CLOCK) begin
    if (scl && !scl_p) rises++;
    if (doe && !oe_p) acks++;
    if (scl && scl_p && sda && !sda_p) begin
      snap0 <= WIPER0;
      snap1 <= WIPER1;
    end
    scl_p <= scl;
    sda_p <= sda;
    oe_p <= doe;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wip();
    chk({6'h0, WIPER0}, {6'h0, e0});
    chk({6'h0, WIPER1}, {6'h0, e1});
    chk({6'h0, snap0}, {6'h0, e0});
    chk({6'h0, snap1}, {6'h0, e1});
  endtask
  // Counts of clock rises and target acks per frame are checked too
  task automatic xfer(input logic rc, input logic gc, input logic hv,
      input logic [1:0] op, input logic [3:0] ad, input logic [9:0] dt,
      input logic ak, input int nr, input int na);
    int r0;
    int a0;
    int k;
    r0 = rises;
    a0 = acks;
    k = 0;
    REQ <= !rc;
    RECOVER <= rc;
    GCALL <= gc;
    HV <= hv;
    A0 <= ad[0];
    OP <= op;
    ADDR <= ad;
    DATA <= dt;
    @(posedge CLOCK);
    REQ <= 1'h0;
    RECOVER <= 1'h0;
    @(negedge CLOCK);
    chk({15'h0, BUSY}, 16'h1);
    do begin
      @(negedge CLOCK);
      k++;
    end while (DONE !== 1'h1 && k < 2000);
    if (k >= 2000) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, k, 2000);
      wrap_up();
    end else begin
      chk({15'h0, ACK_OK}, {15'h0, ak});
      chk({15'h0, BUSY}, 16'h0);
      chk(16'(rises - r0), 16'(nr));
      chk(16'(acks - a0), 16'(na));
      @(posedge CLOCK);
    end
  endtask
  initial begin
    e0 = 10'h080;
    e1 = 10'h080;
    repeat (4) @(posedge CLOCK);
    RST <= 1'h0;
    @(posedge CLOCK);
    wip();
    chk({15'h0, HV_MODE}, 16'h0);
    e0 = 10'h07f;
    xfer(0, 0, 0, OP_DEC, 4'h0, 10'h0, 1, 19, 2);
    wip();
    e1 = 10'h07f;
    xfer(0, 0, 0, OP_DEC, 4'h1, 10'h0, 1, 19, 2);
    wip();
    e0 = 10'h000;
    xfer(0, 0, 0, OP_WRITE, 4'h0, 10'h000, 1, 28, 3);
    xfer(0, 0, 0, OP_DEC, 4'h0, 10'h0, 1, 19, 2);
    wip();
    for (int i = 0; i < 4; i++) begin
      xfer(0, 0, 0, OP_WRITE, 4'h1, vals[i], 1, 28, 3);
      e1 = outs[i];
      xfer(0, 0, 0, OP_DEC, 4'h1, 10'h0, 1, 19, 2);
      wip();
    end
    xfer(0, 0, 0, OP_DEC, 4'h2, 10'h0, 0, 19, 1);
    xfer(0, 0, 0, OP_DEC, 4'hf, 10'h0, 0, 19, 1);
    wip();
    e0 = 10'h055;
    xfer(0, 1, 0, OP_WRITE, 4'h0, 10'h055, 1, 28, 3);
    e1 = 10'h001;
    xfer(0, 1, 0, OP_INC, 4'h1, 10'h0, 1, 19, 2);
    e0 = 10'h054;
    xfer(0, 1, 0, OP_DEC, 4'h0, 10'h0, 1, 19, 2);
    wip();
    e0 = 10'h053;
    xfer(0, 0, 1, OP_DEC, 4'h0, 10'h0, 1, 19, 2);
    chk({15'h0, HV_MODE}, 16'h1);
    e0 = 10'h054;
    xfer(0, 0, 0, OP_INC, 4'h0, 10'h0, 1, 19, 2);
    chk({15'h0, HV_MODE}, 16'h0);
    xfer(1, 0, 0, OP_DEC, 4'h0, 10'h0, 1, 11, 0);
    wip();
    e0 = 10'h053;
    xfer(0, 0, 0, OP_DEC, 4'h0, 10'h0, 1, 19, 2);
    wip();
    wrap_up();
  end
endmodule
`default_nettype wire
